/* File: hw/peew_map.vh */
// pin-level timing constants for the parallel eeprom write/status host
// assumes a 100 MHz mclk; counts derive from the printed times
`ifndef PEEW_MAP_VH
`define PEEW_MAP_VH
`define PEEW_CLK_PS           100_00
// times in ns as printed, write cycle in ms (0.2 us, 30 us, 100 us, 10 ms, 120 ns)
`define PEEW_BLC_MIN_NS       200
`define PEEW_BLC_MAX_NS       30000
`define PEEW_BL_WINDOW_NS     100000
`define PEEW_WC_MS            10
`define PEEW_DB_NS            120
`define PEEW_DW_NS            0
`define PEEW_PULSE_NS         200
// least times round up, longest round down
`define PEEW_BLC_MIN_CYC      ((`PEEW_BLC_MIN_NS + 9) / 10)
`define PEEW_BLC_MAX_CYC      (`PEEW_BLC_MAX_NS / 10)
`define PEEW_WC_CYC           (`PEEW_WC_MS * 100000)
`define PEEW_BL_CYC           (`PEEW_BL_WINDOW_NS / 10)
`define PEEW_PULSE_CYC        ((`PEEW_PULSE_NS + 9) / 10)
`define PEEW_PAGE_BYTES       64
`define PEEW_PAGE_LSB         6
`define PEEW_BIT_POLL         7
`define PEEW_BIT_TOGGLE       6
// status method codes
`define PEEW_M_WAIT           2'h0
`define PEEW_M_POLL           2'h1
`define PEEW_M_TOGGLE         2'h2
`define PEEW_M_RDY            2'h3
`endif

/* File: hw/peew_sync.v */
// two-flop synchroniser for pins from the eeprom
// assumes one clock mclk, async active-high reset
`timescale 1ns/10ps
module peew_sync #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         reset,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule // peew_sync

/* File: hw/peew_host.v */
// host controller driving a byte-wide parallel eeprom by its pins
// assumes pins from the device are asynchronous; mclk at 100 MHz
// Behaviour
// - byte loads spaced 0.2 us to 30 us
// - internal write done within 10 ms
// - next access right after completion reported
// - toggle starts one, poll address fixed
// - hold reset-protect high through operations
// - reset-protect low aborts, hold 10 ms
`timescale 1ns/10ps
`include "peew_map.vh"
module peew_host #(
	parameter WC_CYC  = `PEEW_WC_CYC,
	parameter AW      = 13
) (
	input  wire          mclk,
	input  wire          reset,
	input  wire          cmd_valid,
	input  wire          cmd_write,
	input  wire          cmd_last,
	input  wire [AW-1:0] cmd_addr,
	input  wire [7:0]    cmd_wdata,
	input  wire [1:0]    status_mode,
	output reg           cmd_ready,
	output reg           rsp_valid,
	output reg  [7:0]    rsp_rdata,
	output reg           wr_done,
	output reg           wr_timeout,
	output reg           page_error,
	output reg  [AW-1:0] mem_addr,
	output reg  [7:0]    mem_dout,
	output reg           mem_doe,
	input  wire [7:0]    mem_din,
	output reg           mem_ce_n,
	output reg           mem_oe_n,
	output reg           mem_we_n,
	output reg           reset_protect_n,
	input  wire          ready_busy_n
);
	localparam S_IDLE  = 3'h0;
	localparam S_WLOW  = 3'h1;
	localparam S_WGAP  = 3'h2;
	localparam S_RLOW  = 3'h3;
	localparam S_WAIT  = 3'h4;
	localparam S_PLOW  = 3'h5;
	localparam S_PGAP  = 3'h6;
	localparam CW = 20;
	// 32-bit copies first, so the cut to CW bits is explicit
	localparam [31:0]   PULSE_W  = `PEEW_PULSE_CYC;
	localparam [31:0]   GAPMIN_W = `PEEW_BLC_MIN_CYC;
	localparam [31:0]   GAPMAX_W = `PEEW_BLC_MAX_CYC;
	localparam [31:0]   WC_W     = WC_CYC;
	localparam [31:0]   BL_W     = `PEEW_BL_CYC;
	localparam [CW-1:0] PULSE    = PULSE_W[CW-1:0];
	localparam [CW-1:0] GAPMIN   = GAPMIN_W[CW-1:0];
	localparam [CW-1:0] GAPMAX   = GAPMAX_W[CW-1:0];
	// blind wait spans the idle window before self-start plus the write
	localparam [CW-1:0] WCB      = WC_W[CW-1:0] + BL_W[CW-1:0];

	wire [7:0] din_s;
	wire       rdy_s;
	peew_sync #(.W(9)) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.din   ({ready_busy_n, mem_din}),
		.dout  ({rdy_s, din_s})
	);

	reg [2:0]    st_q;
	reg [CW-1:0] cnt_q;
	reg [CW-1:0] wc_q;
	reg [6:0]    nbytes_q;
	reg [AW-1:0] page_q;
	reg [7:0]    last_q;
	reg          prev6_q;
	reg          first_poll_q;
	reg          in_page_q;

	// a write strobe is held for PULSE+1 cycles, a read strobe for PULSE+3, far above the filter width
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_q <= S_IDLE;
			cnt_q <= {CW{1'b0}};
			wc_q <= {CW{1'b0}};
			nbytes_q <= 7'h00;
			page_q <= {AW{1'b0}};
			last_q <= 8'h00;
			prev6_q <= 1'b0;
			first_poll_q <= 1'b0;
			in_page_q <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			wr_done <= 1'b0;
			wr_timeout <= 1'b0;
			page_error <= 1'b0;
			mem_addr <= {AW{1'b0}};
			mem_dout <= 8'h00;
			mem_doe <= 1'b0;
			mem_ce_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_we_n <= 1'b1;
			reset_protect_n <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			wr_done <= 1'b0;
			wr_timeout <= 1'b0;
			page_error <= 1'b0;
			reset_protect_n <= 1'b1;
			cmd_ready <= 1'b0;
			cnt_q <= cnt_q + 1'b1;
			case (st_q)
			S_IDLE: begin
				cmd_ready <= reset_protect_n;
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					cnt_q <= {CW{1'b0}};
					mem_addr <= cmd_addr;
					mem_ce_n <= 1'b0;
					if (cmd_write) begin
						mem_dout <= cmd_wdata;
						mem_doe <= 1'b1;
						mem_we_n <= 1'b0;
						last_q <= cmd_wdata;
						page_q <= cmd_addr;
						nbytes_q <= 7'h01;
						in_page_q <= 1'b1;
						st_q <= S_WLOW;
					end else begin
						mem_oe_n <= 1'b0;
						st_q <= S_RLOW;
					end
				end
			end
			S_WLOW: if (cnt_q >= PULSE) begin
				mem_we_n <= 1'b1; // data taken here
				mem_ce_n <= 1'b1;
				st_q <= S_WGAP;
			end
			S_WGAP: begin
				mem_doe <= mem_we_n ? mem_doe : 1'b1;
				// next byte only inside the load interval
				cmd_ready <= in_page_q && cnt_q >= GAPMIN &&
					cnt_q < GAPMAX - 2;
				// a closing request never loads its own data
				if (cmd_valid && cmd_ready && cmd_write && !cmd_last &&
					cmd_addr[AW-1:`PEEW_PAGE_LSB] ==
					page_q[AW-1:`PEEW_PAGE_LSB] &&
					nbytes_q < `PEEW_PAGE_BYTES) begin
					cmd_ready <= 1'b0;
					cnt_q <= {CW{1'b0}};
					mem_addr <= cmd_addr;
					mem_dout <= cmd_wdata;
					last_q <= cmd_wdata;
					mem_ce_n <= 1'b0;
					mem_we_n <= 1'b0;
					nbytes_q <= nbytes_q + 7'h01;
					st_q <= S_WLOW;
				end else if ((cmd_valid && cmd_ready && !cmd_last &&
					!cmd_write) || (in_page_q && cnt_q >= GAPMAX - 2)) begin
					// page closed; device starts after idle
					cmd_ready <= 1'b0;
					page_error <= cmd_valid && cmd_ready;
					in_page_q <= 1'b0;
					mem_doe <= 1'b0;
					// polls stay on the last byte's address
					mem_addr <= mem_addr;
					wc_q <= {CW{1'b0}};
					first_poll_q <= 1'b1;
					cnt_q <= {CW{1'b0}};
					st_q <= S_WAIT;
				end else if (cmd_valid && cmd_ready && cmd_last) begin
					cmd_ready <= 1'b0;
					in_page_q <= 1'b0;
					mem_doe <= 1'b0;
					// bit seven only reports on the last byte loaded
					mem_addr <= mem_addr;
					wc_q <= {CW{1'b0}};
					first_poll_q <= 1'b1;
					cnt_q <= {CW{1'b0}};
					st_q <= S_WAIT;
				end
			end
			S_RLOW: if (cnt_q >= PULSE + 2) begin
				rsp_rdata <= din_s; // true byte
				rsp_valid <= 1'b1;
				mem_oe_n <= 1'b1;
				mem_ce_n <= 1'b1;
				st_q <= S_IDLE;
			end
			S_WAIT: begin
				wc_q <= wc_q + 1'b1;
				if (wc_q >= WCB) begin
					wr_timeout <= status_mode != `PEEW_M_WAIT;
					wr_done <= 1'b1;
					st_q <= S_IDLE;
				end else if (status_mode == `PEEW_M_RDY) begin
					// skip the busy-assert delay before trusting the pin
					if (wc_q > (`PEEW_DB_NS / 10) + 4 && rdy_s) begin
						wr_done <= 1'b1;
						st_q <= S_IDLE;
					end
				end else if (status_mode != `PEEW_M_WAIT &&
					cnt_q >= GAPMIN) begin
					cnt_q <= {CW{1'b0}};
					mem_ce_n <= 1'b0;
					mem_oe_n <= 1'b0;
					st_q <= S_PLOW;
				end
			end
			S_PLOW: if (cnt_q >= PULSE + 2) begin
				mem_oe_n <= 1'b1;
				mem_ce_n <= 1'b1;
				cnt_q <= {CW{1'b0}};
				prev6_q <= din_s[`PEEW_BIT_TOGGLE];
				first_poll_q <= 1'b0;
				st_q <= S_WAIT;
				if (status_mode == `PEEW_M_POLL) begin
					if (din_s[`PEEW_BIT_POLL] ==
						last_q[`PEEW_BIT_POLL]) begin
						wr_done <= 1'b1;
						st_q <= S_IDLE;
					end
				end else if (!first_poll_q &&
					din_s[`PEEW_BIT_TOGGLE] == prev6_q) begin
					wr_done <= 1'b1;
					st_q <= S_IDLE;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // peew_host

/* File: verif/peew_properties.sv */
// checker on the host's strobes and request ports
// assumes a bind into peew_host, one clock mclk
`timescale 1ns/10ps
module peew_properties (
	input wire        mclk,
	input wire        reset,
	input wire        cmd_valid,
	input wire        cmd_write,
	input wire        cmd_ready,
	input wire        rsp_valid,
	input wire        page_error,
	input wire [12:0] mem_addr,
	input wire [7:0]  mem_dout,
	input wire        mem_doe,
	input wire        mem_oe_n,
	input wire        mem_we_n,
	input wire        reset_protect_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_we_width:
	assert property ($fell(mem_we_n) |-> ##20 !mem_we_n ##1 mem_we_n)
		else $error("write strobe width");
	a_oe_width:
	assert property ($fell(mem_oe_n) |-> ##22 !mem_oe_n ##1 mem_oe_n)
		else $error("read strobe width");
	a_rp_held:
	assert property ((!mem_we_n || !mem_oe_n) |-> reset_protect_n)
		else $error("protect low in access");
	a_rp_no_drop:
	assert property (!$fell(reset_protect_n)) else $error("protect dropped");
	a_write_drive:
	assert property (!mem_we_n |-> mem_oe_n && mem_doe)
		else $error("write without data drive");
	a_write_stable:
	assert property (!mem_we_n && !$fell(mem_we_n) |->
		$stable(mem_addr) && $stable(mem_dout)) else $error("write pins moved");
	a_poll_addr:
	assert property (!mem_oe_n && !$fell(mem_oe_n) |-> $stable(mem_addr))
		else $error("read address moved");
	a_read_answer:
	assert property (cmd_valid && cmd_ready && !cmd_write |->
		##[1:24] (rsp_valid || page_error)) else $error("read unanswered");
endmodule // peew_properties

/* File: verif/peew_dev.sv */
// behavioural eeprom: page load, self-start, status reads, ready/busy
// assumes host pin levels; times in ns
`timescale 1ns/10ps
module peew_dev #(
	parameter BL_NS = 100000,
	parameter WT_NS = 2000
) (
	input  wire [12:0] addr,
	input  wire [7:0]  din,
	input  wire        ce_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire        rp_n,
	input  wire        slow,
	output reg  [7:0]  dout,
	output reg         rb_low
);
	reg  [7:0]  mem [0:8191];
	reg  [7:0]  last = 0, qd [$];
	reg  [12:0] la = 0, qa [$];
	reg  [6:0]  page = 0;
	reg         busy = 0, run = 0, tog = 1;
	realtime    tf = 0;
	integer     gen = 0;
	wire        wl = !ce_n && !we_n && oe_n;
	wire        rd = !ce_n && !oe_n && we_n && rp_n;
	initial {dout, rb_low} = 9'h14a;
	always @(posedge wl) begin
		tf = $realtime;
		la = addr;
	end
	always @(negedge wl)
		if (rp_n && !run && $realtime - tf > 15 && qa.size() < 64 &&
			(!busy || la[12:6] == page)) begin
			if (!busy) {busy, tog, page} = {2'b11, la[12:6]};
			qa.push_back(la);
			qd.push_back(din);
			last = din;
			gen = gen + 1;
			fork
				start_write(gen);
			join_none
		end
	task automatic start_write(input integer g);
		begin
			#(BL_NS);
			if (g == gen) run = 1;
			if (g == gen) #(slow ? 30000 : WT_NS);
			if (g == gen) begin
				while (qa.size() > 0) mem[qa.pop_front()] = qd.pop_front();
				{busy, run, rb_low} = 3'b000;
			end
		end
	endtask
	always @(posedge busy) #120 rb_low = busy;
	always @(negedge rp_n) begin
		gen = gen + 1;
		qa.delete();
		qd.delete();
		{busy, run, rb_low} = 3'b000;
	end
	// released bus never keeps the last byte
	always @(negedge rd) dout = ~dout;
	always @(posedge rd)
		if (busy) begin
			dout = {~last[7], tog, mem[addr][5:0]};
			tog = !tog;
		end else
			dout = mem[addr];
endmodule // peew_dev

/* File: verif/tb_peew_host.sv */
// bench: a page write in every status mode, then read-back
// assumes peew_host and the eeprom model peew_dev
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_peew_host;
	reg         mclk = 0, reset = 1, cmd_valid = 0, cmd_write = 0, cmd_last = 0;
	reg  [12:0] cmd_addr = 0;
	reg  [7:0]  cmd_wdata = 0, ref_mem [0:8191];
	reg  [6:0]  pg;
	reg  [1:0]  status_mode = 0;
	wire        cmd_ready, rsp_valid, wr_done, wr_timeout, page_error, mem_doe;
	wire        mem_ce_n, mem_oe_n, mem_we_n, reset_protect_n, rb_low;
	wire [12:0] mem_addr;
	wire [7:0]  rsp_rdata, mem_dout, mem_din;
	wire        ready_busy_n = !rb_low; // pulled up when released
	integer     seed = 10, errors = 0, check_count = 0, m, i, n, k;
	integer     pe_cnt = 0;
	peew_host #(.WC_CYC(6000)) peew_host_inst (.*);
	peew_dev peew_dev_inst (.addr(mem_addr), .din(mem_dout),
		.ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
		.rp_n(reset_protect_n), .slow(status_mode[0]), .dout(mem_din),
		.rb_low(rb_low));
	initial forever #5 mclk = ~mclk;
	// page_error stands one cycle; count it while it stands
	always @(negedge mclk) if (page_error === 1'b1) pe_cnt = pe_cnt + 1;
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// pulses stand a full cycle, so the falling edge always sees them
	task hold(input integer w);
		begin
			k = 0;
			while ((w == 0 ? cmd_ready : w == 1 ? wr_done : rsp_valid) !== 1'b1)
			begin
				@(negedge mclk);
				k = k + 1;
				if (k > 30000) begin errors++; wrap_up; end
			end
		end
	endtask
	task req(input w, input l, input [12:0] a, input [7:0] d);
		begin
			{cmd_write, cmd_last, cmd_addr, cmd_wdata} = {w, l, a, d};
			cmd_valid = 1;
			hold(0);
			@(negedge mclk) cmd_valid = 0;
			@(negedge mclk);
		end
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		@(negedge mclk) reset = 0;
		for (m = 0; m < 4; m = m + 1) begin
			status_mode = 2'(m);
			pg = 7'($random(seed));
			n = m ? m + 1 : 64;
			for (i = 0; i < n; i = i + 1) begin
				ref_mem[{pg, i[5:0]}] = 8'($random(seed));
				req(1, 0, {pg, i[5:0]}, ref_mem[{pg, i[5:0]}]);
			end
			req(1, 1, {pg, 6'h00}, 8'h00);
			hold(1);
			`CHK("timeout", 1'b0, wr_timeout)
			`CHK("page_error", 0, pe_cnt)
			for (i = 0; i < n; i = i + 1) begin
				req(0, 0, {pg, i[5:0]}, 8'h00);
				hold(2);
				`CHK("read", ref_mem[{pg, i[5:0]}], rsp_rdata)
			end
			$display("mode %0d done", m);
		end
		// a read in the load gap closes the page and is itself dropped
		pg = 7'($random(seed));
		ref_mem[{pg, 6'h05}] = 8'($random(seed));
		req(1, 0, {pg, 6'h05}, ref_mem[{pg, 6'h05}]);
		req(0, 0, {pg, 6'h00}, 8'h00);
		hold(1);
		`CHK("page_error", 1, pe_cnt)
		`CHK("timeout", 1'b0, wr_timeout)
		req(0, 0, {pg, 6'h05}, 8'h00);
		hold(2);
		`CHK("read", ref_mem[{pg, 6'h05}], rsp_rdata)
		$display("page close by read done");
		wrap_up;
	end
endmodule // tb_peew_host
bind peew_host peew_properties peew_properties_inst (.*);
